// [socket_ctrl_defines.svh]
`ifndef SOCKET_CTRL_DEFINES_SVH
`define SOCKET_CTRL_DEFINES_SVH

// ==========================================================================
// Register map and field layout.
// ==========================================================================
`define SKT_CTRL_OFFSET 8'h10
`define SKT_CTRL_RESET 32'h0000_0400
`define SKT_CTRL_RO_ONE_BIT 10
`define POLICY_BIT 7
`define SUPPLY_MSB 6
`define SUPPLY_LSB 4
`define RSVD_ZERO_BIT 3
`define PROG_MSB 2
`define PROG_LSB 0
`define POLICY_RESET 1'h0
`define REQ_RESET 3'h0

// ==========================================================================
// Voltage request encodings.
// ==========================================================================
`define CODE_OFF 3'h0
`define SUPPLY_5V 3'h2
`define SUPPLY_3V3 3'h3
`define SUPPLY_XV 3'h4
`define SUPPLY_YV 3'h5
`define PROG_12V 3'h1
`define PROG_5V 3'h2
`define PROG_3V3 3'h3
`define PROG_XV 3'h4
`define PROG_YV 3'h5

// ==========================================================================
// Timing and bus answers.
// ==========================================================================
`define IDLE_SOCKET_CLOCKS 4'h8
`define SOCKET_CLK_DIV_LAST 3'h7
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [socket_ctrl_pkg.sv]
package socket_ctrl_pkg;

   // Level actually handed to the socket power switch.
   typedef enum logic [2:0] {LVL_OFF, LVL_12V, LVL_5V, LVL_3V3, LVL_XV, LVL_YV} level_t;

   // Voltages that the inserted card reports it can accept.
   typedef struct packed {
      logic ok_5v;
      logic ok_3v3;
      logic ok_xv;
      logic ok_yv;
   } card_sense_t;

   // Command to the power switch logic.
   typedef struct packed {
      level_t vcc;
      level_t vpp;
      logic update;
   } power_cmd_t;

   // State of the clock halt gate.
   typedef struct packed {
      logic [2:0] div;
      logic [3:0] idle;
      logic permit;
   } halt_state_t;

   // State of the register block.
   typedef struct packed {
      logic policy;
      logic [2:0] supply_req;
      logic [2:0] prog_req;
      power_cmd_t pwr;
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ctrl_state_t;

endpackage

// [clock_halt_gate.sv]
`timescale 1ns/1ps
`include "socket_ctrl_defines.svh"

module clock_halt_gate (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic bus_reset_n,
   input wire logic clock_halt_policy,
   input wire logic socket_busy,
   input wire logic pci_stop_pending,
   output logic stop_permit
);
   import socket_ctrl_pkg::*;

   halt_state_t st_q;
   halt_state_t st_d;

   // ========================================================================
   // Idle counting on socket clock enables.
   // ========================================================================
   // A divider makes the socket clock rate as a one-cycle enable; the idle
   // count saturates so a long idle period never wraps back to busy.
   always_comb begin
      st_d = st_q;
      st_d.div = (st_q.div == `SOCKET_CLK_DIV_LAST) ? 3'h0 : st_q.div + 3'h1;
      if (socket_busy) begin
         st_d.idle = 4'h0;
      end else if (st_q.div == `SOCKET_CLK_DIV_LAST && st_q.idle != `IDLE_SOCKET_CLOCKS) begin
         st_d.idle = st_q.idle + 4'h1;
      end
      st_d.permit = (st_d.idle == `IDLE_SOCKET_CLOCKS) && (clock_halt_policy || pci_stop_pending);
      if (!bus_reset_n) begin
         st_d = '0;
      end
   end

   // State register; the bus reset acts like the global one here.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign stop_permit = st_q.permit;

   // ========================================================================
   // Checks.
   // ========================================================================
   a_halt_needs_pci: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (stop_permit && !$past(clock_halt_policy)) |-> $past(pci_stop_pending))
      else $error("Clock halt permitted without PCI stop pending.");

   a_halt_free_policy: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (st_d.idle == `IDLE_SOCKET_CLOCKS && clock_halt_policy && bus_reset_n) |=> stop_permit)
      else $error("Clock halt not permitted after idle period.");

   a_halt_needs_idle: assert property (
      @(posedge aclk) disable iff (!aresetn)
      stop_permit |-> st_q.idle == `IDLE_SOCKET_CLOCKS)
      else $error("Clock halt permitted before idle period ended.");
endmodule

// [cardbus_socket_control_reg.sv]
`timescale 1ns/1ps
`include "socket_ctrl_defines.svh"

module cardbus_socket_control_reg (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic bus_reset_n,
   input wire logic pme_enable,
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire socket_ctrl_pkg::card_sense_t card_sense,
   input wire logic socket_busy,
   input wire logic pci_stop_pending,
   output socket_ctrl_pkg::power_cmd_t power_cmd,
   output logic stop_permit
);
   import socket_ctrl_pkg::*;

   ctrl_state_t st_q;
   ctrl_state_t st_d;
   logic commit;
   logic hit_w;
   logic hit_r;

   // ========================================================================
   // Decoding helpers.
   // ========================================================================
   // True when the word address selects the control register.
   function automatic logic reg_hit(input logic [7:0] addr);
      reg_hit = (addr[7:2] == 6'(`SKT_CTRL_OFFSET >> 2));
   endfunction

   // Read image; fixed bits come from the reset word, bit 9 stays zero.
   function automatic logic [31:0] reg_image(input logic pol, input logic [2:0] sup, input logic [2:0] prg);
      logic [31:0] img;
      img = `SKT_CTRL_RESET;
      img[`SKT_CTRL_RO_ONE_BIT] = 1'b1;
      img[`POLICY_BIT] = pol;
      img[`SUPPLY_MSB:`SUPPLY_LSB] = sup;
      img[`RSVD_ZERO_BIT] = 1'b0;
      img[`PROG_MSB:`PROG_LSB] = prg;
      reg_image = img;
   endfunction

   // A level already applied stays only while it is still safe; without this a
   // held level would bypass the card check and the supply check for 12 V.
   function automatic level_t keep_safe(input level_t lvl, input card_sense_t s, input level_t vcc);
      unique case (lvl)
         LVL_12V: keep_safe = (vcc != LVL_OFF) ? LVL_12V : LVL_OFF;
         LVL_5V: keep_safe = s.ok_5v ? LVL_5V : LVL_OFF;
         LVL_3V3: keep_safe = s.ok_3v3 ? LVL_3V3 : LVL_OFF;
         LVL_XV: keep_safe = s.ok_xv ? LVL_XV : LVL_OFF;
         LVL_YV: keep_safe = s.ok_yv ? LVL_YV : LVL_OFF;
         default: keep_safe = LVL_OFF;
      endcase
   endfunction

   // Supply code to level; a code the card cannot take gives off, a reserved
   // code keeps the applied level while the card still accepts it.
   function automatic level_t supply_level(input logic [2:0] code, input card_sense_t s, input level_t prev);
      unique case (code)
         `CODE_OFF: supply_level = LVL_OFF;
         `SUPPLY_5V: supply_level = s.ok_5v ? LVL_5V : LVL_OFF;
         `SUPPLY_3V3: supply_level = s.ok_3v3 ? LVL_3V3 : LVL_OFF;
         `SUPPLY_XV: supply_level = s.ok_xv ? LVL_XV : LVL_OFF;
         `SUPPLY_YV: supply_level = s.ok_yv ? LVL_YV : LVL_OFF;
         default: supply_level = keep_safe(prev, s, LVL_OFF);
      endcase
   endfunction

   // Program code to level. 12 V is only offered while the card supply is
   // on, so a card that rejected every supply level never sees it.
   function automatic level_t prog_level(input logic [2:0] code, input card_sense_t s, input level_t vcc,
                                         input level_t prev);
      unique case (code)
         `CODE_OFF: prog_level = LVL_OFF;
         `PROG_12V: prog_level = (vcc != LVL_OFF) ? LVL_12V : LVL_OFF;
         `PROG_5V: prog_level = s.ok_5v ? LVL_5V : LVL_OFF;
         `PROG_3V3: prog_level = s.ok_3v3 ? LVL_3V3 : LVL_OFF;
         `PROG_XV: prog_level = s.ok_xv ? LVL_XV : LVL_OFF;
         `PROG_YV: prog_level = s.ok_yv ? LVL_YV : LVL_OFF;
         default: prog_level = keep_safe(prev, s, vcc);
      endcase
   endfunction

   // A reserved code in the supply field.
   function automatic logic supply_reserved(input logic [2:0] code);
      supply_reserved = (code == 3'h1) || (code == 3'h6) || (code == 3'h7);
   endfunction

   // ========================================================================
   // Next-state logic.
   // ========================================================================
   // Write address and data may arrive in either order or together; the
   // write takes effect once both are held and no response is pending.
   always_comb begin
      st_d = st_q;
      commit = 1'b0;
      hit_w = reg_hit(st_q.aw_addr);
      hit_r = reg_hit(araddr);

      // Retire answers that the master has taken.
      if (st_q.bvalid && bready) begin
         st_d.bvalid = 1'b0;
      end
      if (st_q.rvalid && rready) begin
         st_d.rvalid = 1'b0;
      end

      // Capture write address and write data.
      if (awvalid && st_q.awready) begin
         st_d.aw_got = 1'b1;
         st_d.aw_addr = awaddr;
         hit_w = reg_hit(awaddr);
      end
      if (wvalid && st_q.wready) begin
         st_d.w_got = 1'b1;
         st_d.wdata = wdata;
         st_d.wstrb = wstrb;
      end

      // Perform the write; only byte lane 0 holds writable bits.
      if (st_d.aw_got && st_d.w_got && !st_q.bvalid && bus_reset_n) begin
         commit = 1'b1;
         st_d.aw_got = 1'b0;
         st_d.w_got = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = hit_w ? `RESP_OKAY : `RESP_SLVERR;
         if (hit_w && st_d.wstrb[0]) begin
            st_d.policy = st_d.wdata[`POLICY_BIT];
            st_d.supply_req = st_d.wdata[`SUPPLY_MSB:`SUPPLY_LSB];
            st_d.prog_req = st_d.wdata[`PROG_MSB:`PROG_LSB];
         end
      end

      // Read answer; unmapped reads return zero with an error.
      if (arvalid && st_q.arready) begin
         st_d.rvalid = 1'b1;
         st_d.rresp = hit_r ? `RESP_OKAY : `RESP_SLVERR;
         st_d.rdata = hit_r ? reg_image(st_q.policy, st_q.supply_req, st_q.prog_req) : 32'h0000_0000;
      end

      // Bus reset drops bus traffic and the policy bit; the voltage fields
      // are wake context and survive it while wake signalling is on.
      if (!bus_reset_n) begin
         st_d.aw_got = 1'b0;
         st_d.w_got = 1'b0;
         st_d.bvalid = 1'b0;
         st_d.rvalid = 1'b0;
         st_d.policy = `POLICY_RESET;
         if (!pme_enable) begin
            st_d.supply_req = `REQ_RESET;
            st_d.prog_req = `REQ_RESET;
         end
      end

      // Levels are rechecked every cycle, so a card that stops accepting a
      // level loses it at once rather than at the next write.
      st_d.pwr.vcc = supply_level(st_d.supply_req, card_sense, st_q.pwr.vcc);
      st_d.pwr.vpp = prog_level(st_d.prog_req, card_sense, st_d.pwr.vcc, st_q.pwr.vpp);
      st_d.pwr.update = (st_d.pwr.vcc != st_q.pwr.vcc) || (st_d.pwr.vpp != st_q.pwr.vpp);

      // Ready flags are registered so every bus output leaves a flip-flop.
      st_d.awready = !st_d.aw_got && !st_d.bvalid && bus_reset_n;
      st_d.wready = !st_d.w_got && !st_d.bvalid && bus_reset_n;
      st_d.arready = !st_d.rvalid && bus_reset_n;
   end

   // ========================================================================
   // State register.
   // ========================================================================
   // The global reset clears everything, wake context included.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // ========================================================================
   // Outputs.
   // ========================================================================
   assign awready = st_q.awready;
   assign wready = st_q.wready;
   assign bvalid = st_q.bvalid;
   assign bresp = st_q.bresp;
   assign arready = st_q.arready;
   assign rvalid = st_q.rvalid;
   assign rdata = st_q.rdata;
   assign rresp = st_q.rresp;
   assign power_cmd = st_q.pwr;

   // Card clock halt decision runs off the stored policy bit.
   clock_halt_gate u_halt (
      .aclk(aclk),
      .aresetn(aresetn),
      .bus_reset_n(bus_reset_n),
      .clock_halt_policy(st_q.policy),
      .socket_busy(socket_busy),
      .pci_stop_pending(pci_stop_pending),
      .stop_permit(stop_permit)
   );

   // ========================================================================
   // Checks.
   // ========================================================================
   a_read_fixed_bits: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (rvalid && rresp == `RESP_OKAY) |-> (rdata[31:11] == 21'h0 && rdata[10] && rdata[9:8] == 2'h0))
      else $error("Fixed bits of the control register read wrong.");

   a_read_rsvd_zero: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $rose(rvalid) |-> rdata[3] == 1'b0)
      else $error("Reserved bit 3 read as one.");

   a_vcc_acceptable: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (power_cmd.vcc == LVL_5V && $changed(power_cmd.vcc)) |-> $past(card_sense.ok_5v))
      else $error("5 V supply applied to a card that rejects it.");

   a_supply_decode: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (st_d.supply_req == `SUPPLY_3V3 && card_sense.ok_3v3) |=> power_cmd.vcc == LVL_3V3)
      else $error("Supply code 011 did not apply 3.3 V.");

   a_prog_decode: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (st_d.prog_req == `PROG_12V && st_d.pwr.vcc != LVL_OFF) |=> power_cmd.vpp == LVL_12V)
      else $error("Program code 001 did not apply 12 V.");

   a_prog_reserved: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (st_d.prog_req[2:1] == 2'h3) |=> (power_cmd.vpp == $past(power_cmd.vpp) || power_cmd.vpp == LVL_OFF))
      else $error("Reserved program code changed the applied level.");

   a_supply_reserved: assert property (
      @(posedge aclk) disable iff (!aresetn)
      supply_reserved(st_d.supply_req) |=> (power_cmd.vcc == $past(power_cmd.vcc) || power_cmd.vcc == LVL_OFF))
      else $error("Reserved supply code changed the applied level.");

   a_pme_keeps_req: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!bus_reset_n && pme_enable) |=> ($stable(st_q.supply_req) && $stable(st_q.prog_req)))
      else $error("Bus reset cleared wake context while wake was enabled.");

   a_bus_reset_clr: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!bus_reset_n && !pme_enable) |=> (st_q.supply_req == 3'h0 && st_q.prog_req == 3'h0))
      else $error("Bus reset did not clear the voltage requests.");

   a_write_stores: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (commit && hit_w && st_d.wstrb[0] && bus_reset_n)
      |=> (st_q.policy == $past(st_d.wdata[7]) && st_q.supply_req == $past(st_d.wdata[6:4])))
      else $error("Write did not store the writable fields.");

   a_update_pulse: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ($changed(power_cmd.vcc) || $changed(power_cmd.vpp)) |-> power_cmd.update)
      else $error("Level change not flagged to the power switch.");

   a_vpp_needs_vcc: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (power_cmd.vpp == LVL_12V) |-> (power_cmd.vcc != LVL_OFF))
      else $error("12 V programming voltage applied with the card supply off.");

   a_vcc_3v3_ok: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (power_cmd.vcc == LVL_3V3) |-> $past(card_sense.ok_3v3))
      else $error("3.3 V supply applied to a card that rejects it.");
endmodule

// [socket_partner.sv]
`timescale 1ns/1ps

// ==========================================================================
// Socket far side: card voltage sense, socket activity and switch monitor.
// ==========================================================================
module socket_partner (
   input wire logic aclk,
   input wire socket_ctrl_pkg::card_sense_t accept,
   input wire logic busy_cmd,
   input wire logic stop_cmd,
   input wire socket_ctrl_pkg::power_cmd_t power_cmd,
   output socket_ctrl_pkg::card_sense_t card_sense,
   output logic socket_busy,
   output logic pci_stop_pending,
   output logic [7:0] update_count
);
   import socket_ctrl_pkg::*;

   logic [7:0] count_q = 8'h00;

   // The card reports its acceptable levels as steady levels while inserted.
   assign card_sense = accept;
   assign socket_busy = busy_cmd;
   assign pci_stop_pending = stop_cmd;
   assign update_count = count_q;

   // The power switch counts every new request it is handed.
   always @(posedge aclk) begin
      if (power_cmd.update === 1'b1) begin
         count_q <= count_q + 8'h01;
      end
   end
endmodule

// [cardbus_socket_control_reg_tb_top.sv]
`timescale 1ns/1ps
`include "socket_ctrl_defines.svh"

module cardbus_socket_control_reg_tb_top;
   import socket_ctrl_pkg::*;

   typedef struct {
      logic [31:0] wdata;
      card_sense_t sense;
      level_t vcc;
      level_t vpp;
   } row_t;

   logic aclk, aresetn, bus_reset_n, pme_enable;
   logic [7:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   card_sense_t accept, card_sense;
   logic busy_cmd, stop_cmd, socket_busy, pci_stop_pending, stop_permit;
   power_cmd_t power_cmd;
   logic [7:0] update_count, u0;
   level_t pv, pp;
   int fail_count = 0;
   int tests_run = 0;
   row_t rows[10];

   cardbus_socket_control_reg cardbus_socket_control_reg_i (.aclk(aclk), .aresetn(aresetn),
      .bus_reset_n(bus_reset_n), .pme_enable(pme_enable), .awaddr(awaddr), .awprot(3'h0),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .card_sense(card_sense), .socket_busy(socket_busy),
      .pci_stop_pending(pci_stop_pending), .power_cmd(power_cmd), .stop_permit(stop_permit));

   socket_partner socket_partner_i (.aclk(aclk), .accept(accept), .busy_cmd(busy_cmd),
      .stop_cmd(stop_cmd), .power_cmd(power_cmd), .card_sense(card_sense),
      .socket_busy(socket_busy), .pci_stop_pending(pci_stop_pending), .update_count(update_count));

   // ==========================================================================
   // Clock and shared tasks.
   // ==========================================================================
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      if (fail_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Address and data are offered together; each is dropped at its own handshake edge.
   task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                            output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 200);
      if (bvalid !== 1'b1) fail_count++;
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 200);
      if (rvalid !== 1'b1) fail_count++;
      v = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   // Readies are low during either reset, so the master waits a few edges after release.
   task automatic reset_pulse(input logic glob);
      if (glob) aresetn <= 1'b0;
      else bus_reset_n <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      bus_reset_n <= 1'b1;
      repeat (3) @(posedge aclk);
   endtask

   // A hang is cut short well beyond the few hundred cycles the run needs.
   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      conclude();
   end

   // ==========================================================================
   // Main sequence.
   // ==========================================================================
   initial begin
      rows = '{'{32'h21, 4'hF, LVL_5V, LVL_12V}, '{32'h32, 4'hF, LVL_3V3, LVL_5V},
               '{32'hC3, 4'hF, LVL_XV, LVL_3V3}, '{32'h54, 4'hF, LVL_YV, LVL_XV},
               '{32'h25, 4'hF, LVL_5V, LVL_YV}, '{32'h20, 4'h7, LVL_OFF, LVL_OFF},
               '{32'h34, 4'hF, LVL_3V3, LVL_XV}, '{32'hFFFF_FF1E, 4'hF, LVL_3V3, LVL_XV},
               '{32'h77, 4'hF, LVL_3V3, LVL_XV}, '{32'h00, 4'hF, LVL_OFF, LVL_OFF}};
      aresetn = 1'b0;
      bus_reset_n = 1'b1;
      pme_enable = 1'b0;
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready, busy_cmd, stop_cmd} = '0;
      accept = 4'hF;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      axi_read(`SKT_CTRL_OFFSET, d, r);
      check(d, 32'h0000_0400);
      check(32'(power_cmd.vcc), 32'(LVL_OFF));
      pv = LVL_OFF;
      pp = LVL_OFF;
      // Each row: a card type, a request word, the levels applied and the image read back.
      for (int i = 0; i < 10; i++) begin
         accept <= rows[i].sense;
         repeat (3) @(posedge aclk);
         u0 = update_count;
         axi_write(`SKT_CTRL_OFFSET, rows[i].wdata, 4'hF, r);
         check(32'(r), 32'(`RESP_OKAY));
         repeat (2) @(posedge aclk);
         check(32'(power_cmd.vcc), 32'(rows[i].vcc));
         check(32'(power_cmd.vpp), 32'(rows[i].vpp));
         check(32'(update_count - u0), (rows[i].vcc != pv || rows[i].vpp != pp) ? 32'h1 : 32'h0);
         axi_read(`SKT_CTRL_OFFSET, d, r);
         check(d, 32'h400 | (rows[i].wdata & 32'hF7));
         pv = rows[i].vcc;
         pp = rows[i].vpp;
      end
      // Unmapped place and a write without its low byte strobe leave the register alone.
      axi_write(8'h14, 32'hFF, 4'hF, r);
      check(32'(r), 32'(`RESP_SLVERR));
      axi_read(8'h14, d, r);
      check(32'(r), 32'(`RESP_SLVERR));
      check(d, 32'h0);
      axi_write(`SKT_CTRL_OFFSET, 32'h21, 4'h0, r);
      check(32'(r), 32'(`RESP_OKAY));
      axi_read(`SKT_CTRL_OFFSET, d, r);
      check(d, 32'h400);
      // Programming voltage needs the card supply, even when a reserved code holds it.
      axi_write(`SKT_CTRL_OFFSET, 32'h01, 4'hF, r);
      repeat (2) @(posedge aclk);
      check(32'(power_cmd.vpp), 32'(LVL_OFF));
      axi_write(`SKT_CTRL_OFFSET, 32'h21, 4'hF, r);
      repeat (2) @(posedge aclk);
      check(32'(power_cmd.vpp), 32'(LVL_12V));
      axi_write(`SKT_CTRL_OFFSET, 32'h06, 4'hF, r);
      repeat (2) @(posedge aclk);
      check(32'(power_cmd.vpp), 32'(LVL_OFF));
      // Voltage fields survive the bus reset only while wake signalling is on.
      pme_enable <= 1'b1;
      axi_write(`SKT_CTRL_OFFSET, 32'hA5, 4'hF, r);
      reset_pulse(1'b0);
      axi_read(`SKT_CTRL_OFFSET, d, r);
      check(d, 32'h425);
      pme_enable <= 1'b0;
      reset_pulse(1'b0);
      axi_read(`SKT_CTRL_OFFSET, d, r);
      check(d, 32'h400);
      pme_enable <= 1'b1;
      axi_write(`SKT_CTRL_OFFSET, 32'h25, 4'hF, r);
      reset_pulse(1'b1);
      axi_read(`SKT_CTRL_OFFSET, d, r);
      check(d, 32'h400);
      pme_enable <= 1'b0;
      // Policy clear: an idle socket alone must not stop the card clock.
      repeat (100) @(posedge aclk);
      check(32'(stop_permit), 32'h0);
      stop_cmd <= 1'b1;
      repeat (3) @(posedge aclk);
      check(32'(stop_permit), 32'h1);
      stop_cmd <= 1'b0;
      axi_write(`SKT_CTRL_OFFSET, 32'h80, 4'hF, r);
      repeat (3) @(posedge aclk);
      check(32'(stop_permit), 32'h1);
      // Activity restarts the count; 40 cycles are fewer than 8 idle socket clocks.
      busy_cmd <= 1'b1;
      repeat (3) @(posedge aclk);
      check(32'(stop_permit), 32'h0);
      busy_cmd <= 1'b0;
      repeat (40) @(posedge aclk);
      check(32'(stop_permit), 32'h0);
      repeat (60) @(posedge aclk);
      check(32'(stop_permit), 32'h1);
      conclude();
   end
endmodule
